// ==== inc/sdlc_pkg.sv ====
// constants and types of the serial converter load control block
// assumes one 40 MHz system clock samples every pin of the serial link
package sdlc_pkg;

  localparam int unsigned WORD_W       = 16;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned CNT_W        = 5;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [WORD_W-1:0] MIDSCALE  = 16'h8000;

  // timing of the link seen from the system clock
  localparam int unsigned SYS_CLK_HZ   = 40_000_000;
  localparam int unsigned SCLK_MAX_HZ  = 8_000_000;
  localparam int unsigned SCLK_MIN_CYC = (SYS_CLK_HZ + SCLK_MAX_HZ - 1) / SCLK_MAX_HZ;

  // one completed frame with its converter load request
  typedef struct packed {
    logic              load;
    logic [WORD_W-1:0] code;
  } sdlc_word_t;

  // pins after synchronisation, active-low ones kept as on the pins
  typedef struct packed {
    logic frame_n;
    logic sclk;
    logic serial_in;
    logic load_converter_n;
    logic clear_output_n;
    logic power_down_n;
  } sdlc_pins_t;

  localparam int unsigned PIN_W = $bits(sdlc_pins_t);
  localparam logic [PIN_W-1:0] PIN_IDLE = 6'h3f;

  typedef enum logic [1:0] {
    SDLC_IDLE,
    SDLC_SHIFT,
    SDLC_PUSH
  } sdlc_state_t;

endpackage

// ==== design/sdlc_pin_sync.sv ====
// three-flop synchroniser for a group of asynchronous pins
// assumes pins come from outside the CLK_SYS domain
`timescale 1ns/1ps
`default_nettype none
module sdlc_pin_sync #(
  parameter int unsigned      W       = 1,
  parameter logic [W-1:0]     RST_VAL = '1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  logic [W-1:0] ff1_q, ff2_q, ff3_q, level_q;
  logic [W-1:0] level_d;

  // a change counts once stages two and three agree
  always_comb begin
    level_d = level_q;
    for (int i = 0; i < int'(W); i++) begin
      if (ff2_q[i] == ff3_q[i]) begin
        level_d[i] = ff3_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ff1_q   <= RST_VAL;
      ff2_q   <= RST_VAL;
      ff3_q   <= RST_VAL;
      level_q <= RST_VAL;
    end else begin
      ff1_q   <= pin;
      ff2_q   <= ff1_q;
      ff3_q   <= ff2_q;
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule
`default_nettype wire

// ==== design/sdlc_fifo.sv ====
// synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sdlc_fifo #(
  parameter int unsigned W     = 17,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    push  = in_valid && in_ready;
    pop   = out_valid && out_ready;
    wr_d  = push ? bump(wr_q) : wr_q;
    rd_d  = pop ? bump(rd_q) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

endmodule
`default_nettype wire

// ==== design/sdlc_top.sv ====
// digital control of a 16-bit serial-input converter: shift, load, clear, power-down
// assumes the link pins are asynchronous to CLK_SYS and sampled here at 40 MHz
`timescale 1ns/1ps
`default_nettype none
module sdlc_top #(
  parameter int unsigned FIFO_DEPTH = sdlc_pkg::FIFO_DEPTH
) (
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic        FRAME_N,
  input  wire logic        SCLK,
  input  wire logic        SERIAL_IN,
  input  wire logic        LOAD_CONVERTER_N,
  input  wire logic        CLEAR_OUTPUT_N,
  input  wire logic        POWER_DOWN_N,
  output logic      [15:0] DAC_CODE,
  output logic             OUTPUT_CLEARED,
  output logic             POWERED_DOWN,
  output logic             FRONT_END_ON,
  output logic             SERIAL_OUT_OD_O,
  output logic             SERIAL_OUT_OD_OE_N
);

  sdlc_pkg::sdlc_pins_t  s, prev_q;
  logic [sdlc_pkg::PIN_W-1:0] pin_level;

  // the 40 MHz sampling resolves every edge of a clock up to 8 MHz
  sdlc_pin_sync #(
    .W       (sdlc_pkg::PIN_W),
    .RST_VAL (sdlc_pkg::PIN_IDLE)
  ) u_sync (
    .clk   (CLK_SYS),
    .rst   (SYS_RST),
    .pin   ({FRAME_N, SCLK, SERIAL_IN, LOAD_CONVERTER_N, CLEAR_OUTPUT_N, POWER_DOWN_N}),
    .level (pin_level)
  );

  assign s = sdlc_pins_t_cast(pin_level);

  function automatic sdlc_pkg::sdlc_pins_t sdlc_pins_t_cast(input logic [sdlc_pkg::PIN_W-1:0] v);
    sdlc_pins_t_cast = v;
  endfunction

  function automatic logic fell(input logic was, input logic now);
    fell = was && !now;
  endfunction

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      prev_q <= sdlc_pkg::PIN_IDLE;
    end else begin
      prev_q <= s;
    end
  end

  logic sclk_fall, load_fall, clear_fall;

  always_comb begin
    sclk_fall  = fell(prev_q.sclk, s.sclk);
    load_fall  = fell(prev_q.load_converter_n, s.load_converter_n);
    clear_fall = fell(prev_q.clear_output_n, s.clear_output_n);
  end

  // ---- serial frame capture
  sdlc_pkg::sdlc_state_t           state_q, state_d;
  logic [sdlc_pkg::WORD_W-1:0]     sr_q, sr_d;
  logic [sdlc_pkg::CNT_W-1:0]      cnt_q, cnt_d;
  sdlc_pkg::sdlc_word_t            word_q, word_d;
  logic                            fifo_in_ready;

  always_comb begin
    state_d = state_q;
    sr_d    = sr_q;
    cnt_d   = cnt_q;
    word_d  = word_q;
    unique case (state_q)
      sdlc_pkg::SDLC_IDLE: begin
        // serial clock and data are ignored until frame select falls
        if (!s.frame_n) begin
          state_d = sdlc_pkg::SDLC_SHIFT;
          cnt_d   = '0;
        end
      end
      sdlc_pkg::SDLC_SHIFT: begin
        if (s.frame_n) begin
          if (cnt_q == sdlc_pkg::FRAME_BITS) begin
            word_d.code = sr_q;
            word_d.load = !s.load_converter_n;
            state_d     = sdlc_pkg::SDLC_PUSH;
          end else begin
            state_d = sdlc_pkg::SDLC_IDLE;
          end
        end else if (sclk_fall) begin
          sr_d = {sr_q[sdlc_pkg::WORD_W-2:0], s.serial_in};
          if (cnt_q != sdlc_pkg::FRAME_BITS) begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      sdlc_pkg::SDLC_PUSH: begin
        if (fifo_in_ready) begin
          state_d = sdlc_pkg::SDLC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_q <= sdlc_pkg::SDLC_IDLE;
      sr_q    <= sdlc_pkg::MIDSCALE;
      cnt_q   <= '0;
      word_q  <= '0;
    end else begin
      state_q <= state_d;
      sr_q    <= sr_d;
      cnt_q   <= cnt_d;
      word_q  <= word_d;
    end
  end

  // ---- completed frames queue for the input register
  sdlc_pkg::sdlc_word_t fifo_out;
  logic                 fifo_out_valid, fifo_out_ready;

  sdlc_fifo #(
    .W     ($bits(sdlc_pkg::sdlc_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .in_valid  (state_q == sdlc_pkg::SDLC_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (word_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  // input side frozen in power-down, frames wait in the queue
  assign fifo_out_ready = s.power_down_n;

  // ---- input, converter and output registers
  logic [sdlc_pkg::WORD_W-1:0] in_q, in_d, conv_q, conv_d, dac_q, dac_d;
  logic cleared_q, cleared_d, pd_q, pd_d, fe_q, fe_d, oe_n_q, oe_n_d;
  logic pop, async_ld;

  always_comb begin
    pop      = fifo_out_valid && fifo_out_ready;
    async_ld = load_fall && s.frame_n;
    in_d      = in_q;
    conv_d    = conv_q;
    cleared_d = cleared_q;
    if (pop) begin
      in_d = fifo_out.code;
      if (fifo_out.load) begin
        conv_d    = fifo_out.code;
        cleared_d = 1'b0;
      end
    end else if (async_ld) begin
      conv_d    = in_q;
      cleared_d = 1'b0;
    end
    if (clear_fall) begin
      cleared_d = 1'b1;
    end
    // straight binary passes through, midscale is the zero output
    dac_d  = cleared_d ? sdlc_pkg::MIDSCALE : conv_d;
    pd_d   = !s.power_down_n;
    fe_d   = !s.frame_n;
    oe_n_d = sr_d[sdlc_pkg::WORD_W-1];
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      in_q      <= sdlc_pkg::MIDSCALE;
      conv_q    <= sdlc_pkg::MIDSCALE;
      dac_q     <= sdlc_pkg::MIDSCALE;
      cleared_q <= 1'b0;
      pd_q      <= 1'b0;
      fe_q      <= 1'b0;
      oe_n_q    <= sdlc_pkg::MIDSCALE[sdlc_pkg::WORD_W-1];
    end else begin
      in_q      <= in_d;
      conv_q    <= conv_d;
      dac_q     <= dac_d;
      cleared_q <= cleared_d;
      pd_q      <= pd_d;
      fe_q      <= fe_d;
      oe_n_q    <= oe_n_d;
    end
  end

  // open-drain: only ever drives low, pull-up makes the one
  logic od_o_q;
  always_ff @(posedge CLK_SYS) begin
    od_o_q <= 1'b0;
  end

  assign DAC_CODE           = dac_q;
  assign OUTPUT_CLEARED     = cleared_q;
  assign POWERED_DOWN       = pd_q;
  assign FRONT_END_ON       = fe_q;
  assign SERIAL_OUT_OD_O    = od_o_q;
  assign SERIAL_OUT_OD_OE_N = oe_n_q;

  // ---- checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  chk_front_end_on: assert property ($fell(s.frame_n) |=> FRONT_END_ON)
    else $error("front end not enabled after frame start");
  chk_bit_count_cap: assert property (cnt_q <= sdlc_pkg::FRAME_BITS)
    else $error("bit count above frame length");
  chk_shift_sample: assert property (state_q == sdlc_pkg::SDLC_SHIFT && !s.frame_n && sclk_fall
      |=> sr_q[0] == $past(s.serial_in) && sr_q[15:1] == $past(sr_q[14:0]))
    else $error("serial bit not shifted in");
  chk_async_load: assert property (async_ld && !pop |=> conv_q == $past(in_q))
    else $error("load did not copy input register");
  chk_sync_load: assert property (pop && fifo_out.load |=> conv_q == $past(fifo_out.code))
    else $error("frame end load missed");
  chk_clear_forces: assert property (clear_fall |-> ##1 DAC_CODE == sdlc_pkg::MIDSCALE && OUTPUT_CLEARED)
    else $error("clear did not force zero output");
  chk_clear_keeps: assert property (clear_fall && !pop && !async_ld |=> $stable(conv_q) && $stable(in_q))
    else $error("clear disturbed registers");
  chk_serial_out: assert property (state_q == sdlc_pkg::SDLC_SHIFT && !s.frame_n && sclk_fall
      |=> SERIAL_OUT_OD_OE_N == $past(sr_q[sdlc_pkg::WORD_W-2]))
    else $error("serial output not showing next bit");
  chk_od_low_only: assert property (SERIAL_OUT_OD_O == 1'b0)
    else $error("open-drain output driven high");
  chk_power_down: assert property (!s.power_down_n |-> !fifo_out_ready ##1 POWERED_DOWN)
    else $error("power-down not entered");
  chk_code_path: assert property (!cleared_d |=> DAC_CODE == $past(conv_d))
    else $error("converter code not passed through");
  chk_idle_quiet: assert property (state_q == sdlc_pkg::SDLC_IDLE && s.frame_n |=> $stable(sr_q))
    else $error("shift register moved outside a frame");
  chk_frame_commit: assert property (state_q == sdlc_pkg::SDLC_SHIFT && s.frame_n
      && cnt_q == sdlc_pkg::FRAME_BITS |=> state_q == sdlc_pkg::SDLC_PUSH && word_q.code == $past(sr_q))
    else $error("completed frame not queued");
  chk_short_frame: assert property (state_q == sdlc_pkg::SDLC_SHIFT && s.frame_n
      && cnt_q != sdlc_pkg::FRAME_BITS |=> state_q == sdlc_pkg::SDLC_IDLE)
    else $error("partial frame not discarded");

  cov_full_frame: cover property (state_q == sdlc_pkg::SDLC_PUSH && fifo_in_ready);
  cov_async_load: cover property (async_ld);
  cov_clear: cover property (clear_fall ##[1:1000] async_ld);
  cov_short_frame: cover property (state_q == sdlc_pkg::SDLC_SHIFT && s.frame_n && cnt_q != sdlc_pkg::FRAME_BITS);

endmodule
`default_nettype wire

// ==== sim/sdlc_host_model.sv ====
// host side of the serial link: frames, serial clock, data and readback
// assumes its caller runs the system clock and resolves the open-drain line
`timescale 1ns/1ps
`default_nettype none
module sdlc_host_model (
  input  wire logic clk,
  input  wire logic line,
  output logic      frame_n,
  output logic      sclk,
  output logic      sdata
);
  initial begin
    frame_n = 1'b1;
    sclk    = 1'b1;
    sdata   = 1'b1;
  end

  // n falls msb first, 4 cycles high and low gives 5 MHz
  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge clk);
    frame_n <= 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      sdata <= w[15-i];
      repeat (4) @(negedge clk);
      rd = {rd[14:0], line};
      sclk <= 1'b0;
      repeat (4) @(negedge clk);
      sclk <= 1'b1;
    end
    repeat (4) @(negedge clk);
    frame_n <= 1'b1;
    sdata   <= ~sdata;
  endtask

  // toggling while deselected
  task automatic noise(input int n);
    for (int k = 0; k < n; k++) begin
      sclk  <= 1'(($urandom));
      sdata <= 1'(($urandom));
      repeat (4) @(negedge clk);
    end
    sclk <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench of the converter load control
// assumes the host model drives the link and a pull-up sits on the output
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic            clk;
  logic            rst;
  logic            load_n;
  logic            clr_n;
  logic            pd_n;
  wire logic       frame_n;
  wire logic       sclk;
  wire logic       sdata;
  wire logic       line;
  wire logic [15:0] dac;
  wire logic       cleared;
  wire logic       pwr_dn;
  wire logic       fe_on;
  wire logic       od_o;
  wire logic       oe_n;
  int              error_cnt;
  int              check_count;
  logic [15:0]     exp_q[$];
  logic [15:0]     last;
  logic [15:0]     w;
  logic [15:0]     w3;
  logic [15:0]     rd;
  logic [15:0]     prev;

  assign line = oe_n ? 1'b1 : od_o;

  sdlc_top i_dut (
    .CLK_SYS            (clk),
    .SYS_RST            (rst),
    .FRAME_N            (frame_n),
    .SCLK               (sclk),
    .SERIAL_IN          (sdata),
    .LOAD_CONVERTER_N   (load_n),
    .CLEAR_OUTPUT_N     (clr_n),
    .POWER_DOWN_N       (pd_n),
    .DAC_CODE           (dac),
    .OUTPUT_CLEARED     (cleared),
    .POWERED_DOWN       (pwr_dn),
    .FRONT_END_ON       (fe_on),
    .SERIAL_OUT_OD_O    (od_o),
    .SERIAL_OUT_OD_OE_N (oe_n)
  );

  sdlc_host_model i_host (
    .clk     (clk),
    .line    (line),
    .frame_n (frame_n),
    .sclk    (sclk),
    .sdata   (sdata)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // random code away from midscale and both ends
  function automatic logic [15:0] rnd();
    return {1'b0, 15'($urandom)} | 16'h0001;
  endfunction

  task automatic load_pulse();
    load_n = 1'b0;
    repeat (4) @(negedge clk);
    load_n = 1'b1;
    repeat (20) @(negedge clk);
  endtask

  // every change of the code consumes the oldest expectation
  always @(negedge clk) begin
    if (!rst && dac !== last) begin
      if (exp_q.size() == 0) check(dac, last);
      else check(dac, exp_q.pop_front());
      last = dac;
    end
  end

  initial begin
    #500us;
    error_cnt++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    load_n = 1'b1;
    clr_n = 1'b1;
    pd_n = 1'b1;
    error_cnt = 0;
    check_count = 0;
    last = 16'h8000;
    void'($urandom(7109));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(dac, 16'h8000);
    // held load: update at every frame end
    load_n = 1'b0;
    repeat (10) @(negedge clk);
    prev = 16'h8000;
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : rnd();
      exp_q.push_back(w);
      fork
        i_host.frame(w, 16, rd);
        begin
          repeat (10) @(negedge clk);
          check({15'h0000, fe_on}, 16'h0001);
        end
      join
      check(rd, prev);
      prev = w;
      repeat (20) @(negedge clk);
    end
    check({15'h0000, fe_on}, 16'h0000);
    load_n = 1'b1;
    repeat (10) @(negedge clk);
    // load high: frame parks in the input register
    w = rnd();
    if (w == prev) w ^= 16'h0002;
    i_host.frame(w, 16, rd);
    check(rd, prev);
    repeat (20) @(negedge clk);
    exp_q.push_back(w);
    load_pulse();
    w3 = rnd();
    if (w3 == w) w3 ^= 16'h0002;
    i_host.frame(w3, 16, rd);
    check(rd, w);
    repeat (20) @(negedge clk);
    i_host.frame(rnd(), 10, rd);
    repeat (20) @(negedge clk);
    i_host.noise(40);
    repeat (20) @(negedge clk);
    exp_q.push_back(w3);
    load_pulse();
    // clear forces midscale, input register survives
    exp_q.push_back(16'h8000);
    clr_n = 1'b0;
    repeat (10) @(negedge clk);
    check({15'h0000, cleared}, 16'h0001);
    check(dac, 16'h8000);
    clr_n = 1'b1;
    repeat (20) @(negedge clk);
    exp_q.push_back(w3);
    load_pulse();
    check({15'h0000, cleared}, 16'h0000);
    pd_n = 1'b0;
    repeat (10) @(negedge clk);
    check({15'h0000, pwr_dn}, 16'h0001);
    pd_n = 1'b1;
    repeat (10) @(negedge clk);
    check({15'h0000, pwr_dn}, 16'h0000);
    check(16'(exp_q.size()), 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
